//--- verilog/atc_pkg.sv
// Notes on behaviour
// - addressing-mode bit 1 selects block addressing, 0 selects cylinder/head/sector
// - commands run only when drive-select bit matches socket copy drive number
// - reading primary status clears a pending interrupt request
// - reading alternate status returns same bits, interrupt left pending
// - busy set from command write until command processing finishes
// - busy also held during hardware or software reset
// - write-fault bit 5 set when defect substitution fails
// - seek-complete bit 4 reads one, index bit 1 reads zero
// - data-request bit 3 set only once ready to transfer data
// - corrected-data bit 2 set when a correctable flash error occurred
// - error bit 0 set on failure, cause kept in error register
// - error register: bad block 7, uncorrectable 6, id missing 4, abort 2, general 0
// - device stays in reset while software-reset bit 2 is one
// - interrupt-disable bit 1 masks interrupt output when one
// - standard command set accepted, unlisted codes are invalid
// - card-extension commands erase, write without erase accepted
// - vendor command: sub-code in feature register, then command FFh
// - unlock vendor command must precede other vendor commands
// - raw page read returns all 528 bytes of a page
// - low-level format reinitialises substitution data for every sector
// - information-change stores host data as new card or identify information
// - physical-cylinder command sets largest cylinder, default 1000
package atc_pkg;
    // register indices on the 3-bit task-file address
    localparam logic [2:0] ADDR_ERROR    = 3'h1;
    localparam logic [2:0] ADDR_FEATURE  = 3'h1;
    localparam logic [2:0] ADDR_CYL_LO   = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI   = 3'h5;
    localparam logic [2:0] ADDR_DRVHEAD  = 3'h6;
    localparam logic [2:0] ADDR_STATUS   = 3'h7;
    localparam logic [2:0] ADDR_ALTSTAT  = 3'h6;
    // field positions
    localparam int DH_LBA    = 6;
    localparam int DH_DRV    = 4;
    localparam int ST_BUSY   = 7;
    localparam int ST_RDY    = 6;
    localparam int ST_DWF    = 5;
    localparam int ST_DSC    = 4;
    localparam int ST_DRQ    = 3;
    localparam int ST_CORRECTED_DATA_FLAG   = 2;
    localparam int ST_IDX    = 1;
    localparam int ST_ERR    = 0;
    localparam int DC_SOFT_RESET_BIT   = 2;
    localparam int DC_NIEN   = 1;
    localparam int ER_BBK    = 7;
    localparam int ER_UNC    = 6;
    localparam int ER_SECTOR_ID_MISSING_FLAG   = 4;
    localparam int ER_ABORTED_COMMAND_FLAG   = 2;
    localparam int ER_GEN    = 0;
    // reset values
    localparam logic [7:0] DRVHEAD_RST   = 8'ha0;
    localparam logic [7:0] DEVCTL_RST    = 8'h08;
    localparam logic [15:0] CYL_MAX_RST  = 16'h03e8; // 1000 cylinders
    localparam int          RAW_PAGE_BYTES = 528;
    // vendor command and its sub-codes (sub-code values are arbitrary)
    localparam logic [7:0] CMD_VENDOR     = 8'hff;
    localparam logic [7:0] SUB_LLFORMAT   = 8'h01;
    localparam logic [7:0] SUB_CHGINFO    = 8'h02;
    localparam logic [7:0] SUB_PHYSCYL    = 8'h03;
    localparam logic [7:0] SUB_READALL    = 8'h04;
    localparam logic [7:0] SUB_UNLOCK     = 8'h05;

    typedef enum logic [2:0] {
        OP_INVALID, OP_CONTROL, OP_READ, OP_WRITE,
        OP_LLFORMAT, OP_CHGINFO, OP_PHYSCYL, OP_READALL
    } atc_op_t;

    // completion report from the internal engine
    typedef struct packed {
        logic       done;
        logic       fail;
        logic       substFail;
        logic       corrected;
        logic [7:0] errBits;
    } atc_done_t;

    // host register access strobe
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       ctlBlock;
        logic [2:0] addr;
        logic [7:0] data;
    } atc_host_t;
endpackage

//--- verilog/atc_taskfile.sv
`timescale 1ns/1ps
module atc_taskfile #(
    parameter logic [15:0] CYL_DEFAULT = atc_pkg::CYL_MAX_RST
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire atc_pkg::atc_host_t hostAcc,
    input  wire logic              sockDrive,
    input  wire atc_pkg::atc_done_t engDone,
    input  wire logic              engXferReady,
    output logic [7:0]             rdData,
    output logic                   intReq,
    output logic                   cmdStart,
    output atc_pkg::atc_op_t       cmdOp,
    output logic                   lbaMode,
    output logic [3:0]             headOrBlockAddrTop,
    output logic [15:0]            cylMax,
    output logic                   softResetActive
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESET} atc_state_t;

    atc_state_t       state_r;
    logic [7:0]       driveHead_r;
    logic [7:0]       devCtl_r;
    logic [7:0]       feature_r;
    logic [7:0]       error_r;
    logic [7:0]       rdData_r;
    logic [7:0]       cylLo_r;
    logic [7:0]       cylHi_r;
    logic             busy_r;
    logic             dwf_r;
    logic             drq_r;
    logic             corrected_data_flag_r;
    logic             err_r;
    logic             intPend_r;
    logic             intPend_nxt;
    logic             intReq_r;
    logic             unlocked_r;
    logic             cmdStart_r;
    logic [15:0]      cylMax_r;
    atc_pkg::atc_op_t cmdOp_r;

    // host access decode
    wire wrCmd     = hostAcc.wr & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_STATUS);
    wire wrDh      = hostAcc.wr & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_DRVHEAD);
    wire wrFeat    = hostAcc.wr & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_FEATURE);
    wire wrCylLo   = hostAcc.wr & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_CYL_LO);
    wire wrCylHi   = hostAcc.wr & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_CYL_HI);
    wire wrDevCtl  = hostAcc.wr &  hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_ALTSTAT);
    wire rdStatus  = hostAcc.rd & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_STATUS);
    wire rdAlt     = hostAcc.rd &  hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_ALTSTAT);
    wire rdErr     = hostAcc.rd & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_ERROR);
    wire rdDh      = hostAcc.rd & ~hostAcc.ctlBlock & (hostAcc.addr == atc_pkg::ADDR_DRVHEAD);

    // soft reset held while the control bit stays one; new value takes effect now
    wire srstNow   = wrDevCtl ? hostAcc.data[atc_pkg::DC_SOFT_RESET_BIT] : devCtl_r[atc_pkg::DC_SOFT_RESET_BIT];
    wire driveMatch = (driveHead_r[atc_pkg::DH_DRV] == sockDrive);
    wire cmdAccept  = wrCmd & driveMatch & (state_r == ST_IDLE) & ~srstNow;

    // status image shared by primary and alternate reads
    wire [7:0] statusImg = {busy_r, ~busy_r, dwf_r, 1'b1, drq_r, corrected_data_flag_r, 1'b0, err_r};

    // command decode; vendor codes sit behind the feature sub-code
    atc_pkg::atc_op_t decOp;
    always_comb begin
        case (hostAcc.data)
            8'h20, 8'h21: decOp = atc_pkg::OP_READ;
            8'h22, 8'h23: decOp = atc_pkg::OP_READ;
            8'hc4:        decOp = atc_pkg::OP_READ;
            8'hec:        decOp = atc_pkg::OP_READ;
            8'he4:        decOp = atc_pkg::OP_READ;
            8'h87:        decOp = atc_pkg::OP_READ;
            8'h30, 8'h31: decOp = atc_pkg::OP_WRITE;
            8'h32, 8'h33: decOp = atc_pkg::OP_WRITE;
            8'hc5:        decOp = atc_pkg::OP_WRITE;
            8'he8:        decOp = atc_pkg::OP_WRITE;
            8'h50:        decOp = atc_pkg::OP_WRITE;
            8'h38:        decOp = atc_pkg::OP_WRITE;
            8'hcd:        decOp = atc_pkg::OP_WRITE;
            8'hc0:        decOp = atc_pkg::OP_CONTROL;
            8'h03:        decOp = atc_pkg::OP_CONTROL;
            8'hf5:        decOp = atc_pkg::OP_CONTROL;
            8'h98, 8'he5: decOp = atc_pkg::OP_CONTROL;
            8'h90:        decOp = atc_pkg::OP_CONTROL;
            8'h97, 8'he3: decOp = atc_pkg::OP_CONTROL;
            8'h95, 8'he1: decOp = atc_pkg::OP_CONTROL;
            8'h91:        decOp = atc_pkg::OP_CONTROL;
            8'h40, 8'h41: decOp = atc_pkg::OP_CONTROL;
            8'hef:        decOp = atc_pkg::OP_CONTROL;
            8'hc6:        decOp = atc_pkg::OP_CONTROL;
            8'h99, 8'he6: decOp = atc_pkg::OP_CONTROL;
            8'h96, 8'he2: decOp = atc_pkg::OP_CONTROL;
            8'h94, 8'he0: decOp = atc_pkg::OP_CONTROL;
            atc_pkg::CMD_VENDOR: begin
                if (feature_r == atc_pkg::SUB_UNLOCK)
                    decOp = atc_pkg::OP_CONTROL;
                else if (!unlocked_r)
                    decOp = atc_pkg::OP_INVALID;
                else if (feature_r == atc_pkg::SUB_LLFORMAT)
                    decOp = atc_pkg::OP_LLFORMAT;
                else if (feature_r == atc_pkg::SUB_CHGINFO)
                    decOp = atc_pkg::OP_CHGINFO;
                else if (feature_r == atc_pkg::SUB_PHYSCYL)
                    decOp = atc_pkg::OP_PHYSCYL;
                else if (feature_r == atc_pkg::SUB_READALL)
                    decOp = atc_pkg::OP_READALL;
                else
                    decOp = atc_pkg::OP_INVALID;
            end
            default: begin
                if (hostAcc.data[7:4] == 4'h1 || hostAcc.data[7:4] == 4'h7)
                    decOp = atc_pkg::OP_CONTROL;
                else
                    decOp = atc_pkg::OP_INVALID;
            end
        endcase
    end
    wire isUnlock = (hostAcc.data == atc_pkg::CMD_VENDOR) & (feature_r == atc_pkg::SUB_UNLOCK);
    wire isInvalid = (decOp == atc_pkg::OP_INVALID);

    // read data mux; unmapped reads give zero
    logic [7:0] rdNxt;
    always_comb begin
        if (rdStatus || rdAlt)
            rdNxt = statusImg;
        else if (rdErr)
            rdNxt = error_r;
        else if (rdDh)
            rdNxt = driveHead_r;
        else
            rdNxt = 8'h00;
    end

    // command state machine; reset keeps busy high throughout
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_RESET;
        end else if (srstNow) begin
            state_r <= ST_RESET;
        end else begin
            case (state_r)
                ST_RESET: state_r <= ST_IDLE;
                ST_IDLE:  if (cmdAccept && !isInvalid && !isUnlock) state_r <= ST_EXEC;
                ST_EXEC:  if (engDone.done) state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // busy and data request follow the state machine
    always_ff @(posedge ref_clk) begin
        if (rst || srstNow) begin
            busy_r <= 1'b1;
            drq_r  <= 1'b0;
        end else begin
            busy_r <= (cmdAccept && !isInvalid && !isUnlock) ||
                      (state_r == ST_RESET) ||
                      (state_r == ST_EXEC && !engDone.done);
            drq_r  <= (state_r == ST_EXEC) & engXferReady & ~engDone.done;
        end
    end

    // error register: a new command clears it or, if invalid, sets abort; completion loads the cause
    always_ff @(posedge ref_clk) begin
        if (rst || srstNow)
            error_r <= 8'h00;
        else if (cmdAccept)
            error_r <= isInvalid ? (8'h01 << atc_pkg::ER_ABORTED_COMMAND_FLAG) : 8'h00;
        else if (state_r == ST_EXEC && engDone.done)
            error_r <= engDone.errBits & 8'hd5;
    end

    // error status bit tells the host to look at the error register
    always_ff @(posedge ref_clk) begin
        if (rst || srstNow)
            err_r <= 1'b0;
        else if (cmdAccept)
            err_r <= isInvalid;
        else if (state_r == ST_EXEC && engDone.done)
            err_r <= engDone.fail;
    end

    // write fault is sticky: later commands may misbehave, so only a reset clears it
    always_ff @(posedge ref_clk) begin
        if (rst || srstNow)
            dwf_r <= 1'b0;
        else if (state_r == ST_EXEC && engDone.done)
            dwf_r <= dwf_r | engDone.substFail;
    end

    // corrected-data flag reports the last finished command only
    always_ff @(posedge ref_clk) begin
        if (rst || srstNow)
            corrected_data_flag_r <= 1'b0;
        else if (cmdAccept)
            corrected_data_flag_r <= 1'b0;
        else if (state_r == ST_EXEC && engDone.done)
            corrected_data_flag_r <= engDone.corrected;
    end

    // interrupt pending: completion sets it, primary status read clears it
    wire cmdFinish = (state_r == ST_EXEC && engDone.done) || (cmdAccept && (isInvalid || isUnlock));
    always_comb begin
        if (rst || srstNow)
            intPend_nxt = 1'b0;
        else if (cmdFinish)
            intPend_nxt = 1'b1; // set wins over clear
        else if (rdStatus)
            intPend_nxt = 1'b0;
        else
            intPend_nxt = intPend_r;
    end
    always_ff @(posedge ref_clk) begin
        intPend_r <= intPend_nxt;
    end

    // pin registered from next values, so a mask write acts on the same edge
    wire intMaskNew = wrDevCtl ? hostAcc.data[atc_pkg::DC_NIEN] : devCtl_r[atc_pkg::DC_NIEN];
    always_ff @(posedge ref_clk) begin
        if (rst)
            intReq_r <= 1'b0;
        else
            intReq_r <= intPend_nxt & ~intMaskNew;
    end

    // drive/head: addressing mode, drive select, head or top block bits
    always_ff @(posedge ref_clk) begin
        if (rst)
            driveHead_r <= atc_pkg::DRVHEAD_RST;
        else if (wrDh)
            driveHead_r <= hostAcc.data;
    end

    // device control: soft reset and interrupt mask
    always_ff @(posedge ref_clk) begin
        if (rst)
            devCtl_r <= atc_pkg::DEVCTL_RST;
        else if (wrDevCtl)
            devCtl_r <= hostAcc.data;
    end

    // feature byte selects the vendor sub-command
    always_ff @(posedge ref_clk) begin
        if (rst)
            feature_r <= 8'h00;
        else if (wrFeat)
            feature_r <= hostAcc.data;
    end

    // cylinder bytes; here they only feed the cylinder limit command
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cylLo_r <= 8'h00;
            cylHi_r <= 8'h00;
        end else begin
            if (wrCylLo) cylLo_r <= hostAcc.data;
            if (wrCylHi) cylHi_r <= hostAcc.data;
        end
    end

    // vendor unlock survives soft reset; only a hardware reset locks again
    always_ff @(posedge ref_clk) begin
        if (rst)
            unlocked_r <= 1'b0;
        else if (cmdAccept && isUnlock)
            unlocked_r <= 1'b1;
    end

    // cylinder limit taken from the cylinder bytes as the command is written
    always_ff @(posedge ref_clk) begin
        if (rst)
            cylMax_r <= CYL_DEFAULT;
        else if (cmdAccept && decOp == atc_pkg::OP_PHYSCYL)
            cylMax_r <= {cylHi_r, cylLo_r};
    end

    // read data is valid for the one cycle after the taking edge
    always_ff @(posedge ref_clk) begin
        if (rst)
            rdData_r <= 8'h00;
        else
            rdData_r <= rdNxt;
    end

    // start pulse for the engine; refused and unlock codes never start it
    always_ff @(posedge ref_clk) begin
        if (rst)
            cmdStart_r <= 1'b0;
        else
            cmdStart_r <= cmdAccept & ~isInvalid & ~isUnlock;
    end

    // operation class of the last accepted command
    always_ff @(posedge ref_clk) begin
        if (rst)
            cmdOp_r <= atc_pkg::OP_INVALID;
        else if (cmdAccept)
            cmdOp_r <= decOp;
    end

    assign rdData             = rdData_r;
    assign intReq             = intReq_r;
    assign cmdStart           = cmdStart_r;
    assign cmdOp              = cmdOp_r;
    assign lbaMode            = driveHead_r[atc_pkg::DH_LBA];
    assign headOrBlockAddrTop = driveHead_r[3:0];
    assign cylMax             = cylMax_r;
    assign softResetActive    = devCtl_r[atc_pkg::DC_SOFT_RESET_BIT];
endmodule

//--- verif/atc_taskfile_monitor.sv
`timescale 1ns/1ps
module atc_taskfile_monitor (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire atc_pkg::atc_host_t hostAcc,
    input wire logic               sockDrive,
    input wire atc_pkg::atc_done_t engDone,
    input wire logic [7:0]         rdData,
    input wire logic               intReq,
    input wire logic               cmdStart,
    input wire logic               lbaMode,
    input wire logic [3:0]         headOrBlockAddrTop,
    input wire logic               softResetActive
);
    // decoded host strobes
    wire logic dhWr  = hostAcc.wr && !hostAcc.ctlBlock && hostAcc.addr == 3'h6;
    wire logic cmdWr = hostAcc.wr && !hostAcc.ctlBlock && hostAcc.addr == 3'h7;
    wire logic dcWr  = hostAcc.wr && hostAcc.ctlBlock && hostAcc.addr == 3'h6;
    wire logic stRd  = hostAcc.rd && !hostAcc.ctlBlock && hostAcc.addr == 3'h7;
    wire logic altRd = hostAcc.rd && hostAcc.ctlBlock && hostAcc.addr == 3'h6;
    logic drvBit_r;
    logic nien_r;
    logic run_r;
    // shadow copies so checks need not peek inside the block
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drvBit_r <= atc_pkg::DRVHEAD_RST[4];
            nien_r   <= atc_pkg::DEVCTL_RST[1];
        end else begin
            if (dhWr) drvBit_r <= hostAcc.data[4];
            if (dcWr) nien_r <= hostAcc.data[1];
        end
    end
    // a command runs from its start pulse until the engine reports done
    always_ff @(posedge ref_clk) begin
        if (rst || softResetActive)
            run_r <= 1'b0;
        else if (engDone.done)
            run_r <= 1'b0;
        else if (cmdStart)
            run_r <= 1'b1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_lba; dhWr |=> lbaMode == $past(hostAcc.data[6]); endproperty
    a_lba: assert property (p_lba) else $error("lba mode not taken");
    property p_head; dhWr |=> headOrBlockAddrTop == $past(hostAcc.data[3:0]); endproperty
    a_head: assert property (p_head) else $error("head nibble not taken");
    property p_drvMiss; cmdWr && drvBit_r != sockDrive |=> !cmdStart; endproperty
    a_drvMiss: assert property (p_drvMiss) else $error("command ran for other drive");
    property p_stClr; stRd && !engDone.done |=> !intReq; endproperty
    a_stClr: assert property (p_stClr) else $error("status read left interrupt");
    property p_altKeep; altRd && intReq |=> intReq; endproperty
    a_altKeep: assert property (p_altKeep) else $error("alt status read cleared interrupt");
    property p_fixed; stRd || altRd |=> rdData[4] && !rdData[1]; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
    property p_soft_reset_bit; dcWr |=> softResetActive == $past(hostAcc.data[2]); endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset bit not followed");
    property p_srstCmd; softResetActive && cmdWr |=> !cmdStart; endproperty
    a_srstCmd: assert property (p_srstCmd) else $error("command ran in soft reset");
    property p_mask; nien_r |-> !intReq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt seen");
    property p_done;
        engDone.done && (cmdStart || run_r) && !nien_r && !softResetActive && !dcWr |=> intReq;
    endproperty
    a_done: assert property (p_done) else $error("no interrupt on completion");
    c_start: cover property (cmdStart);
    c_soft_reset_bit: cover property (dcWr && hostAcc.data[2]);
    c_alt: cover property (altRd && intReq);
endmodule
bind atc_taskfile atc_taskfile_monitor i_mon (.ref_clk, .rst, .hostAcc, .sockDrive, .engDone, .rdData,
    .intReq, .cmdStart, .lbaMode, .headOrBlockAddrTop, .softResetActive);

//--- verif/atc_host_model.sv
`timescale 1ns/1ps
// host side: one-cycle strobes; after a strobe the bus data is inverted, never left stale
module atc_host_model (
    input  wire logic         ref_clk,
    input  wire logic [7:0]   rdData,
    output atc_pkg::atc_host_t hostAcc
);
    initial hostAcc = '0;
    // register write, held through the taking edge
    task automatic hwr(input logic c, input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        #1 hostAcc = '{1'b1, 1'b0, c, a, v};
        @(posedge ref_clk);
        #1 hostAcc = '{1'b0, 1'b0, ~c, ~a, ~v};
    endtask
    // register read; data is registered at the taking edge
    task automatic hrd(input logic c, input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        #1 hostAcc = '{1'b0, 1'b1, c, a, 8'h00};
        @(posedge ref_clk);
        #1 hostAcc = '{1'b0, 1'b0, ~c, ~a, 8'hff};
        v = rdData;
    endtask
endmodule

//--- verif/ata_taskfile_command_control_bench.sv
`timescale 1ns/1ps
module ata_taskfile_command_control_bench;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic               sockDrive = 1'b0;
    logic               engXferReady = 1'b0;
    atc_pkg::atc_done_t engDone = '0;
    atc_pkg::atc_host_t hostAcc;
    atc_pkg::atc_op_t   cmdOp;
    logic [7:0]         rdData, d;
    logic [3:0]         headOrBlockAddrTop;
    logic [15:0]        cylMax;
    logic               intReq, cmdStart, lbaMode, softResetActive;
    int                 mismatches = 0;
    int                 tests_run = 0;
    always #50 ref_clk = ~ref_clk;
    atc_host_model i_host (.ref_clk, .rdData, .hostAcc);
    atc_taskfile i_dut (.ref_clk, .rst, .hostAcc, .sockDrive, .engDone, .engXferReady, .rdData, .intReq,
        .cmdStart, .cmdOp, .lbaMode, .headOrBlockAddrTop, .cylMax, .softResetActive);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // engine completion pulse: {fail, substFail, corrected, errBits}
    task automatic fin(input logic [10:0] f);
        @(posedge ref_clk);
        #1 engDone = {1'b1, f};
        @(posedge ref_clk);
        #1 engDone = '0;
    endtask
    // one whole command: feature first for the vendor code, then completion and both status reads
    task automatic run(input logic [7:0] f, input logic [7:0] c, input atc_pkg::atc_op_t op);
        if (c == 8'hff) i_host.hwr(1'b0, 3'h1, f);
        i_host.hwr(1'b0, 3'h7, c);
        chk(cmdStart, 1'b1);
        chk(cmdOp, op);
        i_host.hrd(1'b1, 3'h6, d);
        chk(d[7], 1'b1);
        fin(11'h0);
        chk(intReq, 1'b1);
        i_host.hrd(1'b1, 3'h6, d);
        chk({d, 7'h0, intReq}, 16'h5001);
        i_host.hrd(1'b0, 3'h7, d);
        chk({d, 7'h0, intReq}, 16'h5000);
    endtask
    task automatic s_basic();
        logic [7:0] codes [8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hec, 8'hc0, 8'hcd, 8'h38};
        atc_pkg::atc_op_t ops [8] = '{atc_pkg::OP_READ, atc_pkg::OP_READ, atc_pkg::OP_WRITE,
            atc_pkg::OP_WRITE, atc_pkg::OP_READ, atc_pkg::OP_CONTROL, atc_pkg::OP_WRITE, atc_pkg::OP_WRITE};
        i_host.hrd(1'b0, 3'h7, d);
        chk(d, 8'h50);
        chk(cylMax, 16'd1000);
        i_host.hwr(1'b0, 3'h6, 8'h5b);
        chk({lbaMode, headOrBlockAddrTop}, 5'h1b);
        i_host.hwr(1'b0, 3'h6, 8'ha3);
        chk({lbaMode, headOrBlockAddrTop}, 5'h03);
        foreach (codes[i]) run(8'h00, codes[i], ops[i]);
    endtask
    // refusals: other drive, busy, unlisted code, vendor code while locked
    task automatic s_refuse();
        sockDrive = 1'b1;
        i_host.hwr(1'b0, 3'h7, 8'h20);
        chk(cmdStart, 1'b0);
        sockDrive = 1'b0;
        i_host.hwr(1'b0, 3'h7, 8'h20);
        i_host.hwr(1'b0, 3'h7, 8'h30);
        chk({cmdStart, cmdOp}, {1'b0, atc_pkg::OP_READ});
        fin(11'h0);
        i_host.hrd(1'b0, 3'h7, d);
        i_host.hwr(1'b0, 3'h7, 8'h02);
        chk(cmdStart, 1'b0);
        i_host.hrd(1'b0, 3'h1, d);
        chk({d, 7'h0, intReq}, 16'h0401);
        i_host.hwr(1'b0, 3'h1, 8'h03);
        i_host.hwr(1'b0, 3'h7, 8'hff);
        chk(cmdStart, 1'b0);
        i_host.hrd(1'b0, 3'h7, d);
        chk(d, 8'h51);
    endtask
    task automatic s_vendor();
        i_host.hwr(1'b0, 3'h1, 8'h05);
        i_host.hwr(1'b0, 3'h7, 8'hff);
        @(posedge ref_clk);
        #1 chk(intReq, 1'b1);
        i_host.hrd(1'b0, 3'h7, d);
        chk(d, 8'h50);
        run(8'h01, 8'hff, atc_pkg::OP_LLFORMAT);
        run(8'h02, 8'hff, atc_pkg::OP_CHGINFO);
        run(8'h04, 8'hff, atc_pkg::OP_READALL);
        i_host.hwr(1'b0, 3'h4, 8'he7);
        i_host.hwr(1'b0, 3'h5, 8'h03);
        run(8'h03, 8'hff, atc_pkg::OP_PHYSCYL);
        chk(cylMax, 16'h03e7);
    endtask
    // data request, soft reset, masking, failure report
    task automatic s_ctl();
        i_host.hwr(1'b0, 3'h7, 8'h20);
        engXferReady = 1'b1;
        i_host.hrd(1'b1, 3'h6, d);
        chk(d[3], 1'b1);
        engXferReady = 1'b0;
        i_host.hrd(1'b1, 3'h6, d);
        chk(d[3], 1'b0);
        fin(11'h0);
        i_host.hrd(1'b0, 3'h7, d);
        i_host.hwr(1'b1, 3'h6, 8'h0c);
        i_host.hwr(1'b0, 3'h7, 8'h20);
        chk({softResetActive, cmdStart}, 2'b10);
        i_host.hrd(1'b1, 3'h6, d);
        chk(d[7], 1'b1);
        i_host.hwr(1'b1, 3'h6, 8'h0a);
        repeat (2) @(posedge ref_clk);
        i_host.hwr(1'b0, 3'h7, 8'h20);
        fin(11'h7ff);
        chk(intReq, 1'b0);
        i_host.hwr(1'b1, 3'h6, 8'h08);
        chk(intReq, 1'b1);
        i_host.hrd(1'b1, 3'h6, d);
        chk(d, 8'h75);
        i_host.hrd(1'b0, 3'h1, d);
        chk(d, 8'hd5);
    endtask
    // hardware reset between commands: busy in the cycle after it ends, limit, flags and lock restored
    task automatic s_reset();
        @(posedge ref_clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        i_host.hrd(1'b1, 3'h6, d);
        chk(d, 8'h90);
        chk(intReq, 1'b0);
        chk(cylMax, 16'd1000);
        i_host.hrd(1'b1, 3'h6, d);
        chk(d, 8'h50);
        i_host.hwr(1'b0, 3'h1, 8'h01);
        i_host.hwr(1'b0, 3'h7, 8'hff);
        chk(cmdStart, 1'b0);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        s_basic();
        s_refuse();
        s_vendor();
        s_ctl();
        s_reset();
        give_verdict();
    end
endmodule
